// ===== logic/gpd_top.sv
// Purpose: pin data registers for port A, port B and analog pins plus port A set
// Assumes: pin levels arrive already qualified and synchronous to clk
// Notes: mux and direction settings are inputs from the configuration block

`timescale 1ns/1ns

// Summary of operation
// - Port A data read returns live level of all 32 pins.
// - Port A data write loads latch; drives only general-purpose outputs.
// - Port B uses bits 6-0; bits 31-7 read zero; reads pin levels.
// - Port B data write loads latch; drives only general-purpose outputs.
// - Data reads after reset show pin levels, not a fixed value.
// - Analog data bits 2,4,6,10,12,14 only; other bits read zero.
// - Analog data write drives pin only when a digital output.
// - Writing one to set register forces port A latch high.
// - Zero bits in set writes change nothing; set register reads zero.
// - Data reads take qualified pin level, never the output latch.
// - Reset clears all latches; latches hold until the next write made with ce high.
module gpd_top
	import gpd_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Qualified pin levels
	input wire logic [31:0] port_a_pin_bits,
	input wire logic [6:0] port_b_pin_bits,
	input wire logic [14:0] analog_pin_bit,
	// Pin configuration, one per pin
	input wire logic [31:0] port_a_function_select,
	input wire logic [31:0] port_a_direction,
	input wire logic [6:0] port_b_function_select,
	input wire logic [6:0] port_b_direction,
	input wire logic [14:0] analog_digital_out,
	// Pin drive
	output logic [31:0] port_a_out,
	output logic [31:0] port_a_oe,
	output logic [6:0] port_b_out,
	output logic [6:0] port_b_oe,
	output logic [14:0] analog_out,
	output logic [14:0] analog_oe
);
	import gpd_pkg::*;

	// ----------------------------------------------------------------
	// Decode and latches
	// ----------------------------------------------------------------
	gpd_bus_if bus ();
	logic [31:0] a_latch;
	logic [6:0] b_latch;
	logic [14:0] an_latch;

	gpd_decode u_dec (
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.bus(bus)
	);

	gpd_latch #(.WIDTH(GPD_PORT_A_WIDTH), .MASK(32'hffff_ffff),
		.DATA_SEL(GPD_SEL_A_DATA), .HAS_SET(1'b1)) u_a (
		.clk(clk), .rst(rst), .ce(ce), .bus(bus), .latch_q(a_latch)
	);
	gpd_latch #(.WIDTH(GPD_PORT_B_WIDTH), .MASK(7'h7f),
		.DATA_SEL(GPD_SEL_B_DATA), .HAS_SET(1'b0)) u_b (
		.clk(clk), .rst(rst), .ce(ce), .bus(bus), .latch_q(b_latch)
	);
	gpd_latch #(.WIDTH(GPD_ANALOG_WIDTH), .MASK(GPD_ANALOG_MASK),
		.DATA_SEL(GPD_SEL_ANALOG), .HAS_SET(1'b0)) u_an (
		.clk(clk), .rst(rst), .ce(ce), .bus(bus), .latch_q(an_latch)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Pin levels, not latches, so software sees what the board sees
	wire [31:0] rd_a_w = port_a_pin_bits;
	wire [31:0] rd_b_w = {25'h0, port_b_pin_bits};
	wire [31:0] rd_an_w = {17'h0, analog_pin_bit & GPD_ANALOG_MASK};
	wire [31:0] rd_mux_w = (bus.sel == GPD_SEL_A_DATA) ? rd_a_w :
		(bus.sel == GPD_SEL_B_DATA) ? rd_b_w :
		(bus.sel == GPD_SEL_ANALOG) ? rd_an_w :
		GPD_READ_ZERO;

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= GPD_READ_ZERO;
		end else if (ce) begin
			rdata <= rd ? rd_mux_w : GPD_READ_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Function select high means general-purpose use of the pin
	wire [31:0] a_oe_w = port_a_function_select & port_a_direction;
	wire [6:0] b_oe_w = port_b_function_select & port_b_direction;
	wire [14:0] an_oe_w = analog_digital_out & GPD_ANALOG_MASK;

	// Registered drive adds one cycle of latency after the latch moves
	always_ff @(posedge clk) begin
		if (rst) begin
			port_a_out <= GPD_LATCH_RESET;
			port_a_oe <= GPD_LATCH_RESET;
		end else if (ce) begin
			port_a_out <= a_latch;
			port_a_oe <= a_oe_w;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port_b_out <= GPD_LATCH_RESET[6:0];
			port_b_oe <= GPD_LATCH_RESET[6:0];
		end else if (ce) begin
			port_b_out <= b_latch;
			port_b_oe <= b_oe_w;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			analog_out <= GPD_LATCH_RESET[14:0];
			analog_oe <= GPD_LATCH_RESET[14:0];
		end else if (ce) begin
			analog_out <= an_latch;
			analog_oe <= an_oe_w;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_read_pin_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd && bus.sel == GPD_SEL_A_DATA) |=> rdata == $past(port_a_pin_bits))
		else $error("port A read not pin level");
	b_read_reserved_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd && bus.sel == GPD_SEL_B_DATA) |=> rdata[31:7] == 25'h0)
		else $error("port B reserved bits not zero");
	analog_read_mask_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd) |=> ($past(bus.sel) != GPD_SEL_ANALOG) ||
		((rdata & ~{17'h0, GPD_ANALOG_MASK}) == 32'h0))
		else $error("analog reserved bits not zero");
	set_reads_zero_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd && bus.sel == GPD_SEL_A_SET) |=> rdata == 32'h0)
		else $error("set register read nonzero");
	a_write_drive_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_A_DATA) ##1 ce |=> port_a_out == $past(wdata, 2))
		else $error("port A write not driven");
	b_write_drive_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_B_DATA) ##1 (ce && !wr) |=>
		port_b_out == $past(wdata[6:0], 2))
		else $error("port B write not driven");
	set_forces_high_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_A_SET) ##1 ce |=>
		((port_a_out & $past(wdata, 2)) == $past(wdata, 2)))
		else $error("set write did not raise latch");
	oe_gate_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> analog_oe == ($past(analog_digital_out) & GPD_ANALOG_MASK))
		else $error("analog enable not gated");
	read_idle_a: assert property (@(posedge clk) disable iff (rst)
		(ce && !rd) |=> rdata == 32'h0)
		else $error("read data outside read cycle");

	// ----------------------------------------------------------------
	// Latch and drive checks
	// ----------------------------------------------------------------
	// Each latch moves only for its own strobe
	a_data_latch_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_A_DATA) |=> a_latch == $past(wdata))
		else $error("port A latch not loaded");

	b_data_latch_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_B_DATA) |=> b_latch == $past(wdata[6:0]))
		else $error("port B latch not loaded");

	an_data_latch_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_ANALOG) |=>
		an_latch == ($past(wdata[14:0]) & GPD_ANALOG_MASK))
		else $error("analog latch not loaded");

	a_set_latch_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_A_SET) |=>
		a_latch == ($past(a_latch) | $past(wdata)))
		else $error("set write did not merge into latch");

	set_scope_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_A_SET) |=>
		(b_latch == $past(b_latch)) && (an_latch == $past(an_latch)))
		else $error("set write touched another port");

	a_wr_local_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_A_DATA) |=>
		(b_latch == $past(b_latch)) && (an_latch == $past(an_latch)))
		else $error("port A write touched another port");

	b_wr_local_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_B_DATA) |=>
		(a_latch == $past(a_latch)) && (an_latch == $past(an_latch)))
		else $error("port B write touched another port");

	// Writes outside the map must not disturb any latch
	unmapped_write_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_NONE) |=>
		(a_latch == $past(a_latch)) && (b_latch == $past(b_latch)) &&
		(an_latch == $past(an_latch)))
		else $error("unmapped write changed a latch");

	read_no_side_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd && !wr) |=>
		(a_latch == $past(a_latch)) && (b_latch == $past(b_latch)) &&
		(an_latch == $past(an_latch)))
		else $error("read disturbed a latch");

	a_out_follow_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> port_a_out == $past(a_latch))
		else $error("port A drive not from latch");

	b_out_follow_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> port_b_out == $past(b_latch))
		else $error("port B drive not from latch");

	an_out_follow_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> analog_out == $past(an_latch))
		else $error("analog drive not from latch");

	a_oe_gate_a: assert property (@(posedge clk) disable iff (rst)
		ce |=>
		port_a_oe == $past(port_a_function_select & port_a_direction))
		else $error("port A enable not gated");

	b_oe_gate_a: assert property (@(posedge clk) disable iff (rst)
		ce |=>
		port_b_oe == $past(port_b_function_select & port_b_direction))
		else $error("port B enable not gated");

	a_gp_only_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> (port_a_oe & ~$past(port_a_function_select)) == 32'h0)
		else $error("port A driven without general-purpose function");

	b_gp_only_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> (port_b_oe & ~$past(port_b_function_select)) == 7'h0)
		else $error("port B driven without general-purpose function");

	an_write_drive_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr && bus.sel == GPD_SEL_ANALOG) ##1 ce |=>
		analog_out == ($past(wdata[14:0], 2) & GPD_ANALOG_MASK))
		else $error("analog write not driven");

	// ----------------------------------------------------------------
	// Read checks
	// ----------------------------------------------------------------
	// Read data reflect the pins as sampled at the strobe edge
	b_read_pin_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd && bus.sel == GPD_SEL_B_DATA) |=> rdata[6:0] == $past(port_b_pin_bits))
		else $error("port B read not pin level");

	an_read_pin_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd && bus.sel == GPD_SEL_ANALOG) |=>
		rdata[14:0] == ($past(analog_pin_bit) & GPD_ANALOG_MASK))
		else $error("analog read not pin level");

	unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rd && bus.sel == GPD_SEL_NONE) |=> rdata == 32'h0)
		else $error("unmapped read nonzero");

	// ----------------------------------------------------------------
	// Reset and enable checks
	// ----------------------------------------------------------------
	// Reset wins over the enable, so the reset checks ignore ce
	reset_latch_a: assert property (@(posedge clk)
		rst |=> (a_latch == 32'h0) && (b_latch == 7'h0) && (an_latch == 15'h0) &&
		(rdata == 32'h0))
		else $error("reset left a latch set");

	reset_drive_a: assert property (@(posedge clk)
		rst |=> (port_a_out == 32'h0) && (port_a_oe == 32'h0) &&
		(port_b_out == 7'h0) && (port_b_oe == 7'h0) &&
		(analog_out == 15'h0) && (analog_oe == 15'h0))
		else $error("reset left a pin driven");

	freeze_latch_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(a_latch) && $stable(b_latch) && $stable(an_latch))
		else $error("latch moved while disabled");

	freeze_drive_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(port_a_out) && $stable(port_a_oe) && $stable(port_b_out) &&
		$stable(port_b_oe) && $stable(analog_out) && $stable(analog_oe))
		else $error("pin drive moved while disabled");

	freeze_read_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(rdata))
		else $error("read data moved while disabled");

	cov_set_c: cover property (@(posedge clk) ce && wr && bus.sel == GPD_SEL_A_SET);
	cov_b_rd_c: cover property (@(posedge clk) ce && rd && bus.sel == GPD_SEL_B_DATA);
	cov_an_wr_c: cover property (@(posedge clk) ce && wr && bus.sel == GPD_SEL_ANALOG);
	cov_ce_low_c: cover property (@(posedge clk) !ce && wr);
	cov_a_rd_c: cover property (@(posedge clk) ce && rd && bus.sel == GPD_SEL_A_DATA);
endmodule : gpd_top

// ===== logic/gpd_pkg.sv
// Purpose: constants and types for the pin data and set register block
// Assumes: 32-bit register port, word offsets chosen locally
// Notes: mux and direction settings arrive as inputs

package gpd_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] GPD_OFS_PORT_A_PIN_DATA = 8'h00;
	localparam logic [7:0] GPD_OFS_PORT_B_PIN_DATA = 8'h04;
	localparam logic [7:0] GPD_OFS_ANALOG_PIN_DATA = 8'h08;
	localparam logic [7:0] GPD_OFS_PORT_A_LATCH_SET = 8'h0c;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int GPD_PORT_A_WIDTH = 32;
	localparam int GPD_PORT_B_WIDTH = 7;
	localparam int GPD_ANALOG_WIDTH = 15;
	// Implemented analog bits: 2, 4, 6, 10, 12, 14
	localparam logic [14:0] GPD_ANALOG_MASK = 15'h5454;
	localparam logic [31:0] GPD_LATCH_RESET = 32'h0000_0000;
	localparam logic [31:0] GPD_READ_ZERO = 32'h0000_0000;

	// Decoded register selection
	typedef enum logic [2:0] {
		GPD_SEL_NONE,
		GPD_SEL_A_DATA,
		GPD_SEL_B_DATA,
		GPD_SEL_ANALOG,
		GPD_SEL_A_SET
	} gpd_sel_type;

endpackage : gpd_pkg

// ===== logic/gpd_bus_if.sv
// Purpose: carries decoded register access between the block's modules
// Assumes: one clock domain
// Notes: write strobes are single-cycle pulses

`timescale 1ns/1ns

interface gpd_bus_if;
	import gpd_pkg::*;
	logic wr_en;
	logic [31:0] wr_data;
	gpd_sel_type sel;

	modport decoder (output wr_en, output wr_data, output sel);
	modport latch (input wr_en, input wr_data, input sel);
endinterface : gpd_bus_if

// ===== logic/gpd_decode.sv
// Purpose: decodes the register port address into a register selection
// Assumes: strobes are one cycle long and never together
// Notes: purely combinational

`timescale 1ns/1ns

module gpd_decode
	import gpd_pkg::*;
(
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	// Decoded access
	gpd_bus_if.decoder bus
);
	wire gpd_sel_type sel_w;

	assign sel_w = (addr == GPD_OFS_PORT_A_PIN_DATA) ? GPD_SEL_A_DATA :
		(addr == GPD_OFS_PORT_B_PIN_DATA) ? GPD_SEL_B_DATA :
		(addr == GPD_OFS_ANALOG_PIN_DATA) ? GPD_SEL_ANALOG :
		(addr == GPD_OFS_PORT_A_LATCH_SET) ? GPD_SEL_A_SET : GPD_SEL_NONE;
	assign bus.sel = sel_w;
	assign bus.wr_en = wr;
	assign bus.wr_data = wdata;
endmodule : gpd_decode

// ===== logic/gpd_latch.sv
// Purpose: one output latch bank, loaded by data writes and set writes
// Assumes: only port A owns a set register
// Notes: unimplemented bits never leave zero

`timescale 1ns/1ns

module gpd_latch
	import gpd_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] MASK = '1,
	parameter gpd_sel_type DATA_SEL = GPD_SEL_A_DATA,
	parameter logic HAS_SET = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Access
	gpd_bus_if.latch bus,
	// Latch contents
	output logic [WIDTH-1:0] latch_q
);
	logic [WIDTH-1:0] latch_d;
	wire data_wr_w;
	wire set_wr_w;

	assign data_wr_w = bus.wr_en && (bus.sel == DATA_SEL);
	assign set_wr_w = HAS_SET && bus.wr_en && (bus.sel == GPD_SEL_A_SET);

	// One shared latch for data and set paths
	always_comb begin
		latch_d = latch_q;
		if (data_wr_w) begin
			latch_d = bus.wr_data[WIDTH-1:0] & MASK;
		end
		if (set_wr_w) begin
			latch_d = latch_q | (bus.wr_data[WIDTH-1:0] & MASK);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			latch_q <= GPD_LATCH_RESET[WIDTH-1:0];
		end else if (ce) begin
			latch_q <= latch_d;
		end
	end

	latch_holds_a: assert property (@(posedge clk) disable iff (rst)
		(ce && !data_wr_w && !set_wr_w) |=> latch_q == $past(latch_q))
		else $error("latch changed without a write");
	set_no_clear_a: assert property (@(posedge clk) disable iff (rst)
		(ce && set_wr_w) |=> ((latch_q & $past(latch_q)) == $past(latch_q)))
		else $error("set write cleared a latch bit");
endmodule : gpd_latch

// ===== tb/gpd_pin_model.sv
// Purpose: pad model on the far side of the pin data block
// Assumes: no pulls; an undriven pad shows whatever the outside world drives
// Notes: the bench re-randomises the outside levels every test step

`timescale 1ns/1ns

module gpd_pin_model (
	// Drive from the block
	input wire logic [31:0] a_out,
	input wire logic [31:0] a_oe,
	input wire logic [6:0] b_out,
	input wire logic [6:0] b_oe,
	input wire logic [14:0] n_out,
	input wire logic [14:0] n_oe,
	// Outside levels on undriven pads
	input wire logic [31:0] a_ext,
	input wire logic [6:0] b_ext,
	input wire logic [14:0] n_ext,
	// Pad levels back to the block
	output logic [31:0] a_pin,
	output logic [6:0] b_pin,
	output logic [14:0] n_pin
);
	// ----------------------------------------------------------------
	// Pad resolution
	// ----------------------------------------------------------------
	// A latch value only reaches the pad while the block enables it
	assign a_pin = (a_oe & a_out) | (~a_oe & a_ext);
	assign b_pin = (b_oe & b_out) | (~b_oe & b_ext);
	assign n_pin = (n_oe & n_out) | (~n_oe & n_ext);
endmodule : gpd_pin_model

// ===== tb/gpd_top_tb.sv
// Purpose: self-checking bench for the pin data and set registers
// Assumes: pad levels come from the pad model, outside levels random
// Notes: reads wait two cycles after a write so pads have settled

`timescale 1ns/1ns

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module gpd_top_tb;
	import gpd_pkg::*;
	logic clk, rst, ce, wr, rd;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, r, d, a_pin, a_out, a_oe, fs_a, dir_a, ext_a, la;
	logic [6:0] b_pin, b_out, b_oe, fs_b, dir_b, ext_b, lb;
	logic [14:0] n_pin, n_out, n_oe, dig, ext_n, ln;
	int err_total, comparisons, cycles, op;
	// Expected pad levels, worked out independently of the pad model
	wire [31:0] exp_a = (fs_a & dir_a & la) | (~(fs_a & dir_a) & ext_a);
	wire [6:0] exp_b = (fs_b & dir_b & lb) | (~(fs_b & dir_b) & ext_b);
	wire [14:0] oe_n = dig & GPD_ANALOG_MASK;
	wire [14:0] exp_n = (oe_n & ln) | (~oe_n & ext_n);

	gpd_top u_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .port_a_pin_bits(a_pin), .port_b_pin_bits(b_pin),
		.analog_pin_bit(n_pin), .port_a_function_select(fs_a), .port_a_direction(dir_a),
		.port_b_function_select(fs_b), .port_b_direction(dir_b), .analog_digital_out(dig),
		.port_a_out(a_out), .port_a_oe(a_oe), .port_b_out(b_out), .port_b_oe(b_oe),
		.analog_out(n_out), .analog_oe(n_oe));
	gpd_pin_model u_pins (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
		.n_out(n_out), .n_oe(n_oe), .a_ext(ext_a), .b_ext(ext_b), .n_ext(ext_n),
		.a_pin(a_pin), .b_pin(b_pin), .n_pin(n_pin));

	// ----------------------------------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize();
		if (err_total == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize

	// About 15 cycles a step; the ceiling leaves ample slack
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Register port tasks
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(8042));
		{rst, ce, wr, rd, addr, wdata} = {1'b1, 1'b1, 42'h0};
		{fs_a, dir_a, ext_a, la, fs_b, dir_b, ext_b, lb, dig, ext_n, ln} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK({a_out, b_out, n_out, a_oe}, 86'h0)
		for (int i = 0; i < 80; i++) begin
			@(posedge clk);
			{fs_a, dir_a, ext_a} <= {$urandom, $urandom, $urandom};
			{fs_b, dir_b, ext_b, dig, ext_n} <= 51'({$urandom, $urandom});
			op = $urandom % 6;
			d = $urandom;
			case (op)
				0: begin wr_reg(GPD_OFS_PORT_A_PIN_DATA, d); la = d; end
				1: begin wr_reg(GPD_OFS_PORT_B_PIN_DATA, d); lb = d[6:0]; end
				2: begin wr_reg(GPD_OFS_ANALOG_PIN_DATA, d); ln = d[14:0] & GPD_ANALOG_MASK; end
				3: begin wr_reg(GPD_OFS_PORT_A_LATCH_SET, d); la = la | d; end
				5: begin ce <= 1'b0; wr_reg(GPD_OFS_PORT_A_PIN_DATA, d); ce <= 1'b1; end
				default: wr_reg(8'h10, d);
			endcase
			repeat (2) @(posedge clk);
			#1;
			`CHK(a_oe, fs_a & dir_a)
			`CHK(a_out, la)
			`CHK({b_oe, b_out}, {fs_b & dir_b, lb})
			`CHK({n_oe, n_out}, {oe_n, ln})
			rd_reg(GPD_OFS_PORT_A_PIN_DATA, r);
			`CHK(r, exp_a)
			rd_reg(GPD_OFS_PORT_B_PIN_DATA, r);
			`CHK(r, {25'h0, exp_b})
			rd_reg(GPD_OFS_ANALOG_PIN_DATA, r);
			`CHK(r, {17'h0, exp_n & GPD_ANALOG_MASK})
			rd_reg(GPD_OFS_PORT_A_LATCH_SET, r);
			`CHK(r, 32'h0)
			rd_reg(8'h10, r);
			`CHK(r, 32'h0)
		end
		// Reset again with latches loaded: everything must fall back to zero
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK({a_out, b_out, n_out, a_oe, b_oe, n_oe}, 108'h0)
		@(posedge clk);
		rst <= 1'b0;
		{la, lb, ln} = '0;
		repeat (2) @(posedge clk);
		#1;
		`CHK({a_out, b_out, n_out}, 54'h0)
		summarize();
	end
endmodule : gpd_top_tb
